// ===== common/pcp_pkg.sv
// constants, mode codes and states of the slave parallel configuration port
// How it works
// - mode pins 110 select slave byte loading
// - loaded master keeps addressing, drives chain select low
// - master config clock clocks downstream capture
// - slaves drive low/high-during-config outputs
// - program low floats every configuration pin but init, pulled low, and done
// - reboot off by default, needs 300 ns low
// - reboot reads flash from the other end
// - lowest mode pin low starts at zero upward
// - reboot only flash boot, single device
// - reboot drives pins, program pin untouched
// - host streams until done or init falls
// - bytes sampled on rising config clock
// - busy driven throughout configuration
// - after load pins turn user I/O
// - keep-port option leaves readback port active
// - mode pins captured as init rises
// - busy high means no byte accepted
// - low-during-config low, high-during-config high
`default_nettype none

package pcp_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int REBOOT_MIN_NS = 300;
	// least time, so rounded up to whole cycles
	localparam int REBOOT_CYC = (REBOOT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CNT_W = 16;
	localparam int ADDR_W = 24;
	localparam int BYTE_W = 8;

	localparam logic [2:0] MODE_SLAVE_PAR = 3'h6;
	localparam logic [2:0] MODE_FLASH_UP = 3'h2;
	localparam logic [2:0] MODE_FLASH_DN = 3'h3;

	localparam logic [ADDR_W-1:0] ADDR_BOTTOM = 24'h00_0000;
	localparam logic [ADDR_W-1:0] ADDR_TOP = 24'hff_ffff;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 24'h00_0001;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

	localparam int IMG_BYTES_DEF = 64;
	localparam int STARTUP_CLKS_DEF = 8;
	localparam int INIT_CYC_DEF = 16;
	localparam int CONFIG_CLOCK_HALF_DEF = 4;

	typedef enum logic [2:0] {
		ST_PROG = 3'b000,
		ST_INIT_WAIT = 3'b001,
		ST_LOAD_SLAVE = 3'b010,
		ST_LOAD_FLASH = 3'b011,
		ST_CHAIN = 3'b100,
		ST_STARTUP = 3'b101,
		ST_DONE = 3'b110,
		ST_ERROR = 3'b111
	} pcp_state_e;

endpackage : pcp_pkg

`default_nettype wire

// ===== rtl/pcp_cross.sv
// toggle handshake that carries one word from one clock domain to another
`default_nettype none

module pcp_cross import pcp_pkg::*; #(
	parameter int W = 8
) (
	input wire logic i_src_clk,
	input wire logic i_dst_clk,
	input wire logic i_nrst,
	input wire logic i_src_valid,
	input wire logic [W-1:0] i_src_data,
	output logic o_src_busy,
	output logic o_dst_valid,
	output logic [W-1:0] o_dst_data
);

	typedef struct packed {
		logic req;
		logic [1:0] ack_sync;
		logic [W-1:0] data;
	} pcp_src_s;

	typedef struct packed {
		logic [1:0] req_sync;
		logic req_seen;
		logic valid;
		logic [W-1:0] data;
	} pcp_dst_s;

	pcp_src_s src_ff;
	pcp_src_s nxt_src;
	pcp_dst_s dst_ff;
	pcp_dst_s nxt_dst;

	// busy until the far side has echoed the toggle back
	assign o_src_busy = src_ff.req ^ src_ff.ack_sync[1];
	assign o_dst_valid = dst_ff.valid;
	assign o_dst_data = dst_ff.data;

	always_comb begin
		nxt_src = src_ff;
		nxt_src.ack_sync = {src_ff.ack_sync[0], dst_ff.req_seen};
		// data is latched with the toggle and held while busy, so it is stable when the far side looks
		if (i_src_valid && !o_src_busy) begin
			nxt_src.req = ~src_ff.req;
			nxt_src.data = i_src_data;
		end
	end

	always_comb begin
		nxt_dst = dst_ff;
		nxt_dst.req_sync = {dst_ff.req_sync[0], src_ff.req};
		nxt_dst.req_seen = dst_ff.req_sync[1];
		nxt_dst.valid = dst_ff.req_sync[1] ^ dst_ff.req_seen;
		if (dst_ff.req_sync[1] ^ dst_ff.req_seen) begin
			nxt_dst.data = src_ff.data;
		end
	end

	always_ff @(posedge i_src_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			src_ff <= '0;
		end else begin
			src_ff <= nxt_src;
		end
	end

	always_ff @(posedge i_dst_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			dst_ff <= '0;
		end else begin
			dst_ff <= nxt_dst;
		end
	end

endmodule : pcp_cross

`default_nettype wire

// ===== rtl/pcp_port.sv
// slave parallel and flash boot configuration port with chain hand-over and reboot
`default_nettype none

module pcp_port import pcp_pkg::*; #(
	parameter int IMG_BYTES = IMG_BYTES_DEF,
	parameter int STARTUP_CLKS = STARTUP_CLKS_DEF,
	parameter int INIT_CYC = INIT_CYC_DEF,
	parameter int CONFIG_CLOCK_HALF = CONFIG_CLOCK_HALF_DEF
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_config_clock,
	input wire logic i_program_in_n,
	input wire logic [2:0] i_mode,
	input wire logic [BYTE_W-1:0] i_data,
	input wire logic i_chip_select_n,
	input wire logic i_read_write_ctrl_n,
	input wire logic i_chain_done,
	input wire logic i_reboot_trigger_in,
	input wire logic i_reboot_enable,
	input wire logic i_single_device,
	input wire logic i_keep_port,
	output logic o_init,
	output logic o_init_oe,
	output logic o_done,
	output logic o_done_oe,
	output logic o_busy,
	output logic o_busy_oe,
	output logic [BYTE_W-1:0] o_data,
	output logic o_data_oe,
	output logic [ADDR_W-1:0] o_addr,
	output logic o_addr_oe,
	output logic o_config_clock,
	output logic o_config_clock_oe,
	output logic o_chain_select_out_n,
	output logic o_chain_select_oe,
	output logic [2:0] o_low_during_config_outs,
	output logic o_low_during_config_oe,
	output logic o_high_during_config_out,
	output logic o_high_during_config_oe,
	output logic o_user_io_mode,
	output logic o_config_error,
	output logic [BYTE_W-1:0] o_cfg_byte,
	output logic o_cfg_byte_valid
);

	localparam int IDX_W = $clog2(IMG_BYTES);
	localparam logic [CNT_W-1:0] IMG_LAST = CNT_W'(IMG_BYTES - 1);
	localparam logic [CNT_W-1:0] START_LAST = CNT_W'(STARTUP_CLKS - 1);
	localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(CONFIG_CLOCK_HALF - 1);
	localparam logic [CNT_W-1:0] REBOOT_LAST = CNT_W'(REBOOT_CYC);

	typedef struct packed {
		pcp_state_e state;
		logic [1:0] prog_sync;
		logic [2:0] mode_s1;
		logic [2:0] mode_s2;
		logic [BYTE_W-1:0] data_s1;
		logic [BYTE_W-1:0] data_s2;
		logic [1:0] chdone_sync;
		logic [2:0] mode_cap;
		logic flash_mode;
		logic dir_down;
		logic reboot;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] div_cnt;
		logic config_clock;
		logic [ADDR_W-1:0] addr;
		logic [IDX_W-1:0] wr_idx;
		logic [IDX_W-1:0] rb_idx;
		logic [CNT_W-1:0] trig_cnt;
		logic error;
		logic [BYTE_W-1:0] cfg_byte;
		logic cfg_valid;
		logic rb_valid;
		logic [BYTE_W-1:0] rb_data;
	} pcp_sys_s;

	typedef struct packed {
		logic [1:0] accept_sync;
		logic [1:0] rb_en_sync;
		logic rd_wait;
		logic [BYTE_W-1:0] dout;
		logic dout_oe;
	} pcp_lnk_s;

	pcp_sys_s sys_ff;
	pcp_sys_s nxt_sys;
	pcp_lnk_s lnk_ff;
	pcp_lnk_s nxt_lnk;

	logic [BYTE_W-1:0] img_mem [IMG_BYTES];
	logic mem_we;

	logic req_valid;
	logic [BYTE_W:0] req_data;
	logic req_busy;
	logic sys_req_valid;
	logic [BYTE_W:0] sys_req_data;
	logic ans_valid;
	logic [BYTE_W-1:0] ans_data;

	logic configuring;
	logic accepting;
	logic rb_enable;
	logic flash_drive;
	logic config_clock_rise;
	logic config_clock_fall;
	logic [ADDR_W-1:0] addr_next;

	// link side: bytes and read requests cross from config_clock into i_clk
	pcp_cross #(.W(BYTE_W + 1)) u_req (
		.i_src_clk(i_config_clock),
		.i_dst_clk(i_clk),
		.i_nrst(i_nrst),
		.i_src_valid(req_valid),
		.i_src_data(req_data),
		.o_src_busy(req_busy),
		.o_dst_valid(sys_req_valid),
		.o_dst_data(sys_req_data)
	);

	// readback answers travel the other way
	pcp_cross #(.W(BYTE_W)) u_ans (
		.i_src_clk(i_clk),
		.i_dst_clk(i_config_clock),
		.i_nrst(i_nrst),
		.i_src_valid(sys_ff.rb_valid),
		.i_src_data(sys_ff.rb_data),
		.o_src_busy(),
		.o_dst_valid(ans_valid),
		.o_dst_data(ans_data)
	);

	// busy while a byte or read is still in flight
	assign o_busy = req_busy | lnk_ff.rd_wait;

	always_comb begin
		nxt_lnk = lnk_ff;
		nxt_lnk.accept_sync = {lnk_ff.accept_sync[0], accepting};
		nxt_lnk.rb_en_sync = {lnk_ff.rb_en_sync[0], rb_enable};
		req_valid = 1'b0;
		req_data = {1'b0, i_data};
		// byte taken on the rising config clock
		if (!i_chip_select_n && !o_busy && lnk_ff.accept_sync[1]) begin
			req_valid = 1'b1;
			req_data = {i_read_write_ctrl_n, i_data};
		end else if (!i_chip_select_n && i_read_write_ctrl_n && !o_busy
				&& lnk_ff.rb_en_sync[1]) begin
			// readback request while the port is kept
			req_valid = 1'b1;
			req_data = {1'b1, i_data};
			nxt_lnk.rd_wait = 1'b1;
		end
		if (ans_valid) begin
			nxt_lnk.rd_wait = 1'b0;
			nxt_lnk.dout = ans_data;
		end
		nxt_lnk.dout_oe = lnk_ff.rb_en_sync[1] && !i_chip_select_n && i_read_write_ctrl_n;
	end

	always_ff @(posedge i_config_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			lnk_ff <= '0;
		end else begin
			lnk_ff <= nxt_lnk;
		end
	end

	// system side
	assign configuring = (sys_ff.state != ST_PROG) && (sys_ff.state != ST_DONE);
	assign accepting = !sys_ff.flash_mode
		&& ((sys_ff.state == ST_LOAD_SLAVE) || (sys_ff.state == ST_STARTUP));
	assign rb_enable = (sys_ff.state == ST_DONE) && i_keep_port;
	assign flash_drive = sys_ff.flash_mode && ((sys_ff.state == ST_LOAD_FLASH)
		|| (sys_ff.state == ST_CHAIN) || (sys_ff.state == ST_STARTUP));
	assign config_clock_rise = flash_drive && (sys_ff.div_cnt == HALF_LAST) && !sys_ff.config_clock;
	assign config_clock_fall = flash_drive && (sys_ff.div_cnt == HALF_LAST) && sys_ff.config_clock;
	assign addr_next = sys_ff.dir_down ? sys_ff.addr - ADDR_STEP : sys_ff.addr + ADDR_STEP;
	assign mem_we = nxt_sys.cfg_valid;

	always_comb begin
		nxt_sys = sys_ff;
		nxt_sys.prog_sync = {sys_ff.prog_sync[0], i_program_in_n};
		nxt_sys.mode_s1 = i_mode;
		nxt_sys.mode_s2 = sys_ff.mode_s1;
		nxt_sys.data_s1 = i_data;
		nxt_sys.data_s2 = sys_ff.data_s1;
		nxt_sys.chdone_sync = {sys_ff.chdone_sync[0], i_chain_done};
		nxt_sys.cfg_valid = 1'b0;
		nxt_sys.rb_valid = 1'b0;

		// master makes the config clock by division
		if (flash_drive) begin
			nxt_sys.div_cnt = (sys_ff.div_cnt == HALF_LAST) ? CNT_ZERO : sys_ff.div_cnt + CNT_ONE;
			if (sys_ff.div_cnt == HALF_LAST) begin
				nxt_sys.config_clock = ~sys_ff.config_clock;
			end
		end else begin
			nxt_sys.div_cnt = CNT_ZERO;
			nxt_sys.config_clock = 1'b0;
		end
		// address moves on the falling edge so data is settled at the rise
		if (config_clock_fall) begin
			nxt_sys.addr = addr_next;
		end

		case (sys_ff.state)
			ST_PROG: begin
				nxt_sys.reboot = 1'b0;
				nxt_sys.error = 1'b0;
				nxt_sys.cnt = CNT_ZERO;
				if (sys_ff.prog_sync[1]) begin
					nxt_sys.state = ST_INIT_WAIT;
				end
			end
			ST_INIT_WAIT: begin
				nxt_sys.cnt = sys_ff.cnt + CNT_ONE;
				nxt_sys.wr_idx = '0;
				nxt_sys.rb_idx = '0;
				if (sys_ff.cnt == INIT_LAST) begin
					nxt_sys.cnt = CNT_ZERO;
					if (sys_ff.reboot) begin
						// reboot drives the flash pins again, program stays released
						nxt_sys.addr = sys_ff.dir_down ? ADDR_BOTTOM : ADDR_TOP;
						nxt_sys.dir_down = ~sys_ff.dir_down;
						nxt_sys.state = ST_LOAD_FLASH;
					end else begin
						// mode captured as init is released
						nxt_sys.mode_cap = sys_ff.mode_s2;
						if (sys_ff.mode_s2 == MODE_SLAVE_PAR) begin
							nxt_sys.flash_mode = 1'b0;
							nxt_sys.state = ST_LOAD_SLAVE;
						end else if ((sys_ff.mode_s2 == MODE_FLASH_UP)
								|| (sys_ff.mode_s2 == MODE_FLASH_DN)) begin
							// lowest mode pin low starts at address zero, counting up
							nxt_sys.flash_mode = 1'b1;
							nxt_sys.dir_down = sys_ff.mode_s2[0];
							nxt_sys.addr = sys_ff.mode_s2[0] ? ADDR_TOP : ADDR_BOTTOM;
							nxt_sys.state = ST_LOAD_FLASH;
						end else begin
							nxt_sys.state = ST_ERROR;
						end
					end
				end
			end
			ST_LOAD_SLAVE: begin
				if (sys_req_valid) begin
					if (sys_req_data[BYTE_W]) begin
						// read/write control high while loading is an error
						nxt_sys.error = 1'b1;
						nxt_sys.state = ST_ERROR;
					end else begin
						nxt_sys.cfg_byte = sys_req_data[BYTE_W-1:0];
						nxt_sys.cfg_valid = 1'b1;
						nxt_sys.wr_idx = sys_ff.wr_idx + IDX_W'(1);
						nxt_sys.cnt = sys_ff.cnt + CNT_ONE;
						if (sys_ff.cnt == IMG_LAST) begin
							nxt_sys.cnt = CNT_ZERO;
							nxt_sys.state = ST_STARTUP;
						end
					end
				end
			end
			ST_LOAD_FLASH: begin
				if (config_clock_rise) begin
					nxt_sys.cfg_byte = sys_ff.data_s2;
					nxt_sys.cfg_valid = 1'b1;
					nxt_sys.wr_idx = sys_ff.wr_idx + IDX_W'(1);
					nxt_sys.cnt = sys_ff.cnt + CNT_ONE;
					if (sys_ff.cnt == IMG_LAST) begin
						nxt_sys.cnt = CNT_ZERO;
						nxt_sys.state = i_single_device ? ST_STARTUP : ST_CHAIN;
					end
				end
			end
			ST_CHAIN: begin
				// keep addressing for the next device until it reports done
				if (sys_ff.chdone_sync[1]) begin
					nxt_sys.state = ST_STARTUP;
				end
			end
			ST_STARTUP: begin
				// start-up runs on extra config clocks, never on i_clk alone
				if ((sys_ff.flash_mode && config_clock_rise) || (!sys_ff.flash_mode && sys_req_valid)) begin
					nxt_sys.cnt = sys_ff.cnt + CNT_ONE;
					if (sys_ff.cnt == START_LAST) begin
						nxt_sys.cnt = CNT_ZERO;
						nxt_sys.trig_cnt = CNT_ZERO;
						nxt_sys.state = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				if (sys_req_valid && sys_req_data[BYTE_W]) begin
					nxt_sys.rb_data = img_mem[sys_ff.rb_idx];
					nxt_sys.rb_valid = 1'b1;
					nxt_sys.rb_idx = (sys_ff.rb_idx == IDX_W'(IMG_BYTES - 1)) ? '0
						: sys_ff.rb_idx + IDX_W'(1);
				end
				// trigger counted only while enabled, low for the least time
				if (!i_reboot_trigger_in && i_reboot_enable) begin
					if (sys_ff.trig_cnt != REBOOT_LAST) begin
						nxt_sys.trig_cnt = sys_ff.trig_cnt + CNT_ONE;
					end
				end else begin
					nxt_sys.trig_cnt = CNT_ZERO;
				end
				// only a single flash-booted device reboots
				if (i_reboot_trigger_in && (sys_ff.trig_cnt == REBOOT_LAST)
						&& sys_ff.flash_mode && i_single_device) begin
					nxt_sys.reboot = 1'b1;
					nxt_sys.cnt = CNT_ZERO;
					nxt_sys.state = ST_INIT_WAIT;
				end
			end
			ST_ERROR: begin
				nxt_sys.error = 1'b1;
			end
			default: begin
				nxt_sys.state = ST_PROG;
			end
		endcase

		// program low aborts everything and floats the pins except init and done
		if (!sys_ff.prog_sync[1]) begin
			nxt_sys.state = ST_PROG;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sys_ff <= '0;
		end else begin
			sys_ff <= nxt_sys;
		end
	end

	// loaded image kept for readback; no reset needed on plain storage
	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			img_mem[sys_ff.wr_idx] <= nxt_sys.cfg_byte;
		end
	end

	// byte register only moves on a stored byte, so it doubles as the output flop
	assign o_cfg_byte = sys_ff.cfg_byte;
	assign o_cfg_byte_valid = sys_ff.cfg_valid;
	assign o_config_error = sys_ff.error;

	// init is open drain: pulled low in program, init wait and error
	assign o_init = 1'b0;
	assign o_init_oe = (sys_ff.state == ST_PROG) || (sys_ff.state == ST_INIT_WAIT)
		|| (sys_ff.state == ST_ERROR);
	assign o_done = (sys_ff.state == ST_DONE);
	assign o_done_oe = 1'b1;

	// busy driven for the whole load, and while the port is kept
	assign o_busy_oe = configuring || rb_enable;

	// data pins driven only for readback
	assign o_data = lnk_ff.dout;
	assign o_data_oe = lnk_ff.dout_oe && rb_enable;

	assign o_addr = sys_ff.addr;
	assign o_addr_oe = flash_drive;
	assign o_config_clock = sys_ff.config_clock;
	assign o_config_clock_oe = flash_drive;

	// chain select low hands the stream to the next device
	assign o_chain_select_out_n = (sys_ff.state != ST_CHAIN);
	assign o_chain_select_oe = configuring;

	// config indicator pins driven throughout loading
	assign o_low_during_config_outs = 3'h0;
	assign o_low_during_config_oe = configuring;
	assign o_high_during_config_out = 1'b1;
	assign o_high_during_config_oe = configuring;

	// released to user logic after load unless kept
	assign o_user_io_mode = (sys_ff.state == ST_DONE) && !i_keep_port;

endmodule : pcp_port

`default_nettype wire

// ===== test/pcp_checker.sv
// assertions on the pins of the configuration port
`default_nettype none

module pcp_checker (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_program_in_n,
	input wire logic o_init_oe,
	input wire logic o_done,
	input wire logic o_busy_oe,
	input wire logic o_addr_oe,
	input wire logic o_config_clock_oe,
	input wire logic o_chain_select_out_n,
	input wire logic o_chain_select_oe,
	input wire logic [2:0] o_low_during_config_outs,
	input wire logic o_low_during_config_oe,
	input wire logic o_high_during_config_out,
	input wire logic o_high_during_config_oe,
	input wire logic o_user_io_mode,
	input wire logic o_config_error,
	input wire logic o_cfg_byte_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	chk_busy_driven: assert property (!o_done && !o_init_oe |-> o_busy_oe)
		else $error("busy floats while loading");
	chk_cfg_levels: assert property (o_low_during_config_oe |->
		o_low_during_config_outs == 3'h0 && o_high_during_config_out)
		else $error("config level pins wrong");
	chk_pins_driven: assert property (!o_done && !o_init_oe |->
		o_low_during_config_oe && o_high_during_config_oe)
		else $error("config level pins float");
	// two sync stages plus the state register, with one edge of margin
	chk_prog_float: assert property (!i_program_in_n [*5] |-> !o_addr_oe && !o_busy_oe &&
		!o_chain_select_oe && !o_config_clock_oe && !o_low_during_config_oe)
		else $error("pin driven while program low");
	chk_chain_clock: assert property (!o_chain_select_out_n |-> o_addr_oe && o_config_clock_oe)
		else $error("chain select without clock");
	chk_user_io: assert property (o_user_io_mode |-> o_done && !o_busy_oe &&
		!o_addr_oe && !o_low_during_config_oe)
		else $error("pin kept after load");
	chk_done_init: assert property (o_done |-> !o_init_oe)
		else $error("init low while done");
	chk_error_init: assert property (o_config_error |-> o_init_oe)
		else $error("error without init low");
	chk_no_late: assert property (o_cfg_byte_valid |-> !o_done && !o_user_io_mode)
		else $error("byte taken after done");

	cov_done: cover property (o_done);
	cov_error: cover property (o_config_error);
	cov_chain: cover property (!o_chain_select_out_n && o_chain_select_oe);
	cov_byte: cover property (o_cfg_byte_valid);
endmodule : pcp_checker

`default_nettype wire

// ===== test/pcp_host_model.sv
// host processor writing bytes over the slave parallel port
`default_nettype none

module pcp_host_model import pcp_pkg::*; (
	input wire logic i_busy,
	output logic o_config_clock,
	output logic o_chip_select_n,
	output logic o_read_write_ctrl_n,
	output logic [BYTE_W-1:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_config_clock = 1'b0;
		o_chip_select_n = 1'b1;
		o_read_write_ctrl_n = 1'b0;
		o_data = 8'h00;
	end

	// select low and read/write set from rd together with the byte; hold it while busy
	task automatic put(input logic [BYTE_W-1:0] b, input logic rd, input int gap,
		output logic ok);
		logic held;
		int n;
		held = 1'b1;
		n = 0;
		// clock stands still between frames
		#(16 + 64 * gap);
		o_chip_select_n = 1'b0;
		o_read_write_ctrl_n = rd;
		o_data = b;
		while (held && n < 64) begin
			#32;
			held = i_busy;
			o_config_clock = 1'b1;
			#32;
			o_config_clock = 1'b0;
			n++;
		end
		ok = !held;
		// a dropped byte must not look stable
		o_data = ~b;
	endtask : put

	// write control back low while not reading
	task automatic idle(input int n);
		o_chip_select_n = 1'b1;
		o_read_write_ctrl_n = 1'b0;
		repeat (n) begin
			#32 o_config_clock = 1'b1;
			#32 o_config_clock = 1'b0;
		end
	endtask : idle
endmodule : pcp_host_model

`default_nettype wire

// ===== test/tb_top.sv
// bench: host and flash stimulus around the configuration port
`default_nettype none

module tb_top import pcp_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IMG = 8;
	localparam int SUP = 2;
	logic i_clk, i_nrst, i_program_in_n, i_chain_done, i_reboot_trigger_in;
	logic i_reboot_enable, i_single_device, i_keep_port, flash, ok;
	logic i_config_clock, i_chip_select_n, i_read_write_ctrl_n;
	logic o_init_oe, o_done, o_busy, o_busy_oe, o_data_oe, o_addr_oe, o_config_clock_oe;
	logic o_chain_select_out_n, o_low_during_config_oe, o_user_io_mode, o_config_error;
	logic o_cfg_byte_valid;
	logic [2:0] i_mode;
	logic [BYTE_W-1:0] i_data, hdata, fdata, o_cfg_byte, o_data, img0;
	logic [ADDR_W-1:0] o_addr;
	logic [BYTE_W-1:0] expq[$];
	int seed, n_mismatch, comparisons, cyc;

	assign i_data = flash ? fdata : hdata;
	pcp_port #(.IMG_BYTES(IMG), .STARTUP_CLKS(SUP), .INIT_CYC(4), .CONFIG_CLOCK_HALF(4)) i_dut (
		.i_clk, .i_nrst, .i_config_clock, .i_program_in_n, .i_mode, .i_data,
		.i_chip_select_n, .i_read_write_ctrl_n, .i_chain_done, .i_reboot_trigger_in,
		.i_reboot_enable, .i_single_device, .i_keep_port, .o_init(), .o_init_oe,
		.o_done, .o_done_oe(), .o_busy, .o_busy_oe, .o_data, .o_data_oe, .o_addr,
		.o_addr_oe, .o_config_clock(), .o_config_clock_oe, .o_chain_select_out_n,
		.o_chain_select_oe(), .o_low_during_config_outs(), .o_low_during_config_oe,
		.o_high_during_config_out(), .o_high_during_config_oe(), .o_user_io_mode,
		.o_config_error, .o_cfg_byte, .o_cfg_byte_valid);
	pcp_host_model i_host (.i_busy(o_busy_oe ? o_busy : 1'b0), .o_config_clock(i_config_clock),
		.o_chip_select_n(i_chip_select_n), .o_read_write_ctrl_n(i_read_write_ctrl_n),
		.o_data(hdata));

	function automatic logic [BYTE_W-1:0] fb(input logic [ADDR_W-1:0] a);
		return a[7:0] ^ 8'ha5;
	endfunction : fb

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	task automatic prog(input logic [2:0] m);
		i_host.idle(0);
		@(posedge i_clk);
		i_program_in_n <= 1'b0;
		i_mode <= m;
		repeat (6) @(posedge i_clk);
		check({o_addr_oe, o_busy_oe, o_data_oe, o_config_clock_oe}, 0);
		i_program_in_n <= 1'b1;
		for (int i = 0; i < 300 && o_init_oe; i++) @(posedge i_clk);
		check(o_init_oe, 0);
	endtask : prog

	task automatic load_slave(input int n);
		logic [BYTE_W-1:0] b;
		i_host.idle(6);
		for (int i = 0; i < n + SUP; i++) begin
			b = BYTE_W'($random(seed));
			if (i < n) expq.push_back(b);
			if (i == 0) img0 = b;
			i_host.put(b, 1'b0, $random(seed) & 3, ok);
			check(ok, 1);
		end
	endtask : load_slave

	task automatic wait_done(input logic exp);
		for (int i = 0; i < 4000 && !o_done; i++) @(posedge i_clk);
		check(o_done, exp);
		check(expq.size(), 0);
	endtask : wait_done

	task automatic pulse(input int n, input logic exp_done);
		@(posedge i_clk);
		i_reboot_trigger_in <= 1'b0;
		repeat (n) @(posedge i_clk);
		i_reboot_trigger_in <= 1'b1;
		repeat (6) @(posedge i_clk);
		check(o_done, exp_done);
	endtask : pulse

	task automatic wait_addr();
		for (int i = 0; i < 300 && !o_addr_oe; i++) @(posedge i_clk);
	endtask : wait_addr

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		fdata <= fb(o_addr);
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			wrap_up();
		end
		if (o_cfg_byte_valid && expq.size() > 0) check(o_cfg_byte, expq.pop_front());
	end

	initial begin
		{seed, n_mismatch, comparisons, cyc} = {32'd64, 32'd0, 32'd0, 32'd0};
		{i_nrst, i_program_in_n, i_chain_done, i_reboot_enable, i_keep_port} = 5'h08;
		{i_reboot_trigger_in, i_single_device, flash, i_mode} = 6'h36;
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		prog(MODE_SLAVE_PAR);
		load_slave(IMG);
		wait_done(1'b1);
		check({o_user_io_mode, o_addr_oe, o_busy_oe}, 3'h4);
		i_keep_port <= 1'b1;
		prog(MODE_SLAVE_PAR);
		load_slave(IMG);
		wait_done(1'b1);
		check(o_busy_oe, 1);
		i_host.put(8'h00, 1'b1, 0, ok);
		repeat (4) @(posedge i_clk);
		check(o_data_oe, 1);
		i_host.idle(6);
		check(o_data, img0);
		check(o_busy, 0);
		i_keep_port <= 1'b0;
		prog(MODE_SLAVE_PAR);
		load_slave(3);
		i_host.put(8'h3c, 1'b1, 0, ok);
		i_host.idle(3);
		repeat (30) @(posedge i_clk);
		check({o_config_error, o_init_oe}, 2'h3);
		expq.delete();
		flash <= 1'b1;
		for (int i = 0; i < IMG; i++) expq.push_back(fb(ADDR_BOTTOM + ADDR_W'(i)));
		prog(MODE_FLASH_UP);
		wait_addr();
		check(o_addr, ADDR_BOTTOM);
		wait_done(1'b1);
		pulse(REBOOT_CYC + 2, 1'b1);
		i_reboot_enable <= 1'b1;
		for (int i = 0; i < IMG; i++) expq.push_back(fb(ADDR_TOP - ADDR_W'(i)));
		pulse(REBOOT_CYC, 1'b0);
		wait_addr();
		check(o_addr, ADDR_TOP);
		wait_done(1'b1);
		i_single_device <= 1'b0;
		prog(MODE_FLASH_DN);
		for (int i = 0; i < 4000 && o_chain_select_out_n; i++) @(posedge i_clk);
		check({o_chain_select_out_n, o_config_clock_oe, o_addr_oe}, 3'h3);
		i_chain_done <= 1'b1;
		wait_done(1'b1);
		pulse(REBOOT_CYC, 1'b1);
		wrap_up();
	end
endmodule : tb_top

bind pcp_port pcp_checker i_chk (.i_clk, .i_nrst, .i_program_in_n, .o_init_oe, .o_done,
	.o_busy_oe, .o_addr_oe, .o_config_clock_oe, .o_chain_select_out_n, .o_chain_select_oe,
	.o_low_during_config_outs, .o_low_during_config_oe, .o_high_during_config_out,
	.o_high_during_config_oe, .o_user_io_mode, .o_config_error, .o_cfg_byte_valid);

`default_nettype wire
